// ==== verilog/capture_pkg.sv ====
/*
 * shared constants for the video capture mode control block:
 * shutter lengths, mode table fields, reset values and rate codes.
 * assumes a single 40 MHz clock domain and jumper selects on pins.
 */
package capture_pkg;
    // shutter pulse lengths in lines, indexed by 3-bit select
    localparam logic [7:0] SHUT_LEN_7 = 8'h00_F5; // 245 lines
    localparam logic [7:0] SHUT_LEN_6 = 8'h00_80; // 128 lines
    localparam logic [7:0] SHUT_LEN_5 = 8'h00_40; // 64 lines
    localparam logic [7:0] SHUT_LEN_4 = 8'h00_20; // 32 lines
    localparam logic [7:0] SHUT_LEN_3 = 8'h00_10; // 16 lines
    localparam logic [7:0] SHUT_LEN_2 = 8'h00_08; // 8 lines
    localparam logic [7:0] SHUT_LEN_1 = 8'h00_04; // 4 lines
    localparam logic [7:0] SHUT_LEN_0 = 8'h00_02; // 2 lines
    // clock rate and sample rates in kilohertz
    localparam int CLK_KHZ       = 40000;  // MCLK rate
    localparam int FULL_RATE_KHZ = 7160;   // full horizontal sampling
    localparam int HALF_RATE_KHZ = 3580;   // half horizontal sampling
    // sample tick period in clock cycles (both periods round down)
    localparam int FULL_DIV = CLK_KHZ / FULL_RATE_KHZ; // 5 cycles
    localparam int HALF_DIV = CLK_KHZ / HALF_RATE_KHZ; // 11 cycles
    // dropped low bits in bypass reduction
    localparam int BYPASS_DROP = 5;
    // reset value of the latched mode word
    localparam logic [4:0] MODE_RST = 5'h00_00;
    // serial bit rate codes
    typedef enum logic [1:0] {
        BR_7M16 = 2'h0, BR_3M58 = 2'h1, BR_1M79 = 2'h2, BR_0M895 = 2'h3
    } bit_rate_t;
    // frame rate codes
    typedef enum logic [1:0] {
        FR_30 = 2'h0, FR_15 = 2'h1, FR_7P5 = 2'h2, FR_3P75 = 2'h3
    } frame_rate_t;
endpackage : capture_pkg

// ==== verilog/mode_decode.sv ====
/*
 * combinational decoder of the sixteen legal operating modes.
 * assumes the mode word is already latched and stable.
 */
module mode_decode (
    input  wire logic [4:0] mode,       // {six, br1, br0, fr1, fr0}
    output logic            legal,      // combination is in the table
    output logic            full_horiz, // full horizontal resolution
    output logic            full_vert,  // full vertical resolution
    output logic            part_loss   // mode loses part of picture
);
    import capture_pkg::*;

    // table lookup, bit one = right position
    always_comb begin
        legal      = 1'b1;
        full_horiz = 1'b0;
        full_vert  = 1'b0;
        part_loss  = 1'b0;
        case (mode)
            5'h1F: begin full_horiz = 1'b1; end
            5'h1B: begin full_horiz = 1'b1; full_vert = 1'b1;
                part_loss = 1'b1; end
            5'h1A: begin full_horiz = 1'b1; end
            5'h16: begin full_horiz = 1'b1; full_vert = 1'b1; end
            5'h15: begin full_horiz = 1'b1; end
            5'h11: begin full_horiz = 1'b1; full_vert = 1'b1; end
            5'h10: begin full_horiz = 1'b1; end
            5'h0F: begin end
            5'h0B: begin full_horiz = 1'b1; end
            5'h0A: begin end
            5'h07: begin full_horiz = 1'b1; full_vert = 1'b1;
                part_loss = 1'b1; end
            5'h06: begin full_horiz = 1'b1; end
            5'h05: begin end
            5'h02: begin full_horiz = 1'b1; full_vert = 1'b1; end
            5'h01: begin full_horiz = 1'b1; end
            5'h00: begin end
            default: begin legal = 1'b0; end
        endcase
    end
endmodule : mode_decode

// ==== verilog/capture_ctrl.sv ====
/*
 * video capture mode control: shutter pulse, input select, clamp,
 * overlay tag insertion, mode select latching and pixel reduction.
 * assumes line/field/clamp strobes come from pins (synchronised here)
 * and that jumper selects are static pins sampled after reset.
 */
// How it works
// - shutter length follows 3-bit select table
// - shutter rises line zero, falls at length
// - route exactly one of four inputs
// - clamp switches closed only during clamp pulse
// - sample every 5 or 11 clocks (8 or about 3.64 MSPS) by horizontal resolution
// - first line: tag drives top bits, else released
// - both top bits carry tag value
// - three or six bit pixels, H/V resolution
// - bit rate select sets serial rate
// - frame rate select sets frame rate
// - only sixteen legal modes, two lose picture
// - compression select picks algorithm or bypass
// - bypass keeps top three pixel bits
module capture_ctrl #(
    parameter int LINE_W = 9 // line counter width
) (
    input  wire logic       MCLK,          // 40 MHz clock
    input  wire logic       RESET_N,       // async reset, active low
    input  wire logic       CLK_EN,        // freezes state when low
    input  wire logic [2:0] SHUT_SEL,      // shutter length select
    input  wire logic       FIELD_START,   // field start strobe pin
    input  wire logic       LINE_START,    // line period strobe pin
    input  wire logic       LINE_ACTIVE,   // line active pin
    input  wire logic       CLAMP_PULSE,   // back porch clamp pin
    input  wire logic       FIRST_LINE,    // first line of frame pin
    input  wire logic [1:0] INPUT_SEL,     // video input select
    input  wire logic       PIX_SIX,       // six-bit pixel select
    input  wire logic [1:0] BIT_RATE_SEL,  // bit rate select
    input  wire logic [1:0] FRAME_RATE_SEL,// frame rate select
    input  wire logic       COMP_RIGHT,    // 1 = compress, 0 = bypass
    input  wire logic       OVERLAY_IN,    // overlay generator value
    input  wire logic [7:0] PIXEL_IN,      // converter output pixel
    output logic            SHUTTER,       // shutter pulse
    output logic [3:0]      INPUT_EN,      // one-hot mux enable
    output logic            CLAMP_CLOSE,   // clamp switches closed
    output logic            SAMPLE_TICK,   // converter sample strobe
    output logic            TOP_BITS_OE,   // converter top bits enable
    output logic            OVL_OE,        // overlay drives top bits
    output logic            OVL_OUT,       // overlay drive value
    output logic [7:0]      PIXEL_OUT,     // pixel with tag inserted
    output logic [2:0]      BYPASS_PIX,    // bypass reduced pixel
    output logic            PIX_SIX_OUT,   // six-bit format active
    output logic            COMPRESS_ON,   // compression selected
    output logic [1:0]      BIT_RATE,      // latched bit rate code
    output logic [1:0]      FRAME_RATE,    // latched frame rate code
    output logic            HORIZ_FULL,    // full horizontal res
    output logic            VERT_FULL,     // full vertical res
    output logic            MODE_ILLEGAL,  // illegal mode flag
    output logic            PART_LOSS      // partial picture loss
);
    import capture_pkg::*;

    // refuse a counter too narrow to reach the longest shutter length
    if (LINE_W < 8) begin : g_width_chk
        $error("line counter too narrow");
    end

    typedef enum logic [1:0] {ST_LATCH, ST_RUN} run_t; // mode phase

    // three-stage synchronisers for pin strobes
    logic [4:0] sync1_ff, sync2_ff, sync3_ff; // stages
    logic [4:0] in_pins;                      // raw pins
    assign in_pins = {FIRST_LINE, CLAMP_PULSE, LINE_ACTIVE,
                      LINE_START, FIELD_START};
    logic [4:0] lvl_ff, nxt_lvl;              // debounced levels
    logic [4:0] prev_ff;                      // previous level

    // mode, shutter and counters
    run_t              run_ff, nxt_run;       // mode phase
    logic [4:0]        mode_ff, nxt_mode;     // latched jumpers
    logic [2:0]        shsel_ff, nxt_shsel;   // latched shutter select
    logic              comp_ff, nxt_comp;     // latched compression
    logic [LINE_W-1:0] line_ff, nxt_line;     // line counter
    logic              shut_ff, nxt_shut;     // shutter pulse
    logic [3:0]        div_ff, nxt_div;       // sample divider
    logic [7:0]        shut_len;              // selected length
    logic              legal, fh, fv, pl;     // decoded mode
    logic              field_rise, line_rise; // strobe edges

    mode_decode u_dec (
        .mode       (mode_ff),
        .legal      (legal),
        .full_horiz (fh),
        .full_vert  (fv),
        .part_loss  (pl)
    );

    // shutter length lookup
    always_comb begin
        case (shsel_ff)
            3'h7:    shut_len = SHUT_LEN_7;
            3'h6:    shut_len = SHUT_LEN_6;
            3'h5:    shut_len = SHUT_LEN_5;
            3'h4:    shut_len = SHUT_LEN_4;
            3'h3:    shut_len = SHUT_LEN_3;
            3'h2:    shut_len = SHUT_LEN_2;
            3'h1:    shut_len = SHUT_LEN_1;
            default: shut_len = SHUT_LEN_0;
        endcase
    end

    // level accepted once stages two and three agree
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            nxt_lvl[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i]
                                                     : lvl_ff[i];
        end
    end
    assign field_rise = lvl_ff[0] & ~prev_ff[0];
    assign line_rise  = lvl_ff[1] & ~prev_ff[1];

    // next state of mode, counters and shutter
    always_comb begin
        nxt_run   = run_ff;
        nxt_mode  = mode_ff;
        nxt_shsel = shsel_ff;
        nxt_comp  = comp_ff;
        nxt_line  = line_ff;
        nxt_shut  = shut_ff;
        nxt_div   = div_ff;
        case (run_ff)
            ST_LATCH: begin
                nxt_mode  = {PIX_SIX, BIT_RATE_SEL, FRAME_RATE_SEL};
                nxt_shsel = SHUT_SEL;
                nxt_comp  = COMP_RIGHT;
                nxt_run   = ST_RUN;
            end
            ST_RUN: begin
                if (field_rise) begin
                    nxt_line = '0;
                end else if (line_rise) begin
                    nxt_line = line_ff + 1'b1;
                end
                if (line_ff == '0 && lvl_ff[2] && !field_rise) begin
                    nxt_shut = 1'b1;
                end else if (line_ff >= LINE_W'(shut_len)) begin
                    nxt_shut = 1'b0;
                end
                // sample divider by resolution
                if (div_ff == 4'(((HORIZ_FULL ? FULL_DIV
                                   : HALF_DIV) - 1))) begin
                    nxt_div = 4'h0_0;
                end else begin
                    nxt_div = div_ff + 4'h0_1;
                end
            end
            default: nxt_run = ST_LATCH;
        endcase
    end

    // register all state
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            lvl_ff   <= '0;
            prev_ff  <= '0;
            run_ff   <= ST_LATCH;
            mode_ff  <= MODE_RST;
            shsel_ff <= 3'h0_0;
            comp_ff  <= 1'b0;
            line_ff  <= '0;
            shut_ff  <= 1'b0;
            div_ff   <= 4'h0_0;
        end else if (CLK_EN) begin
            sync1_ff <= in_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            lvl_ff   <= nxt_lvl;
            prev_ff  <= lvl_ff;
            run_ff   <= nxt_run;
            mode_ff  <= nxt_mode;
            shsel_ff <= nxt_shsel;
            comp_ff  <= nxt_comp;
            line_ff  <= nxt_line;
            shut_ff  <= nxt_shut;
            div_ff   <= nxt_div;
        end
    end

    // output next values
    logic [3:0] nxt_inen;  // one-hot input enable
    logic       nxt_ovl;   // tag window
    logic [7:0] nxt_pix;   // tagged pixel
    always_comb begin
        nxt_inen = 4'h0_0;
        nxt_inen[INPUT_SEL] = 1'b1;
        nxt_ovl  = lvl_ff[4];
        nxt_pix  = PIXEL_IN;
        if (nxt_ovl) begin
            nxt_pix[7:6] = {2{OVERLAY_IN}};
        end
    end

    // output registers
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SHUTTER      <= 1'b0;
            INPUT_EN     <= 4'h0_1;
            CLAMP_CLOSE  <= 1'b0;
            SAMPLE_TICK  <= 1'b0;
            TOP_BITS_OE  <= 1'b1;
            OVL_OE       <= 1'b0;
            OVL_OUT      <= 1'b0;
            PIXEL_OUT    <= 8'h00_00;
            BYPASS_PIX   <= 3'h0_0;
            PIX_SIX_OUT  <= 1'b0;
            COMPRESS_ON  <= 1'b0;
            BIT_RATE     <= 2'h0_0;
            FRAME_RATE   <= 2'h0_0;
            HORIZ_FULL   <= 1'b0;
            VERT_FULL    <= 1'b0;
            MODE_ILLEGAL <= 1'b0;
            PART_LOSS    <= 1'b0;
        end else if (CLK_EN) begin
            SHUTTER      <= shut_ff;
            INPUT_EN     <= nxt_inen;
            CLAMP_CLOSE  <= lvl_ff[3];
            SAMPLE_TICK  <= (run_ff == ST_RUN) && (div_ff == 4'h0_0);
            TOP_BITS_OE  <= ~nxt_ovl;
            OVL_OE       <= nxt_ovl;
            OVL_OUT      <= nxt_ovl & OVERLAY_IN;
            PIXEL_OUT    <= nxt_pix;
            BYPASS_PIX   <= PIXEL_IN[7:BYPASS_DROP];
            PIX_SIX_OUT  <= mode_ff[4];
            COMPRESS_ON  <= comp_ff;
            BIT_RATE     <= mode_ff[3:2];
            FRAME_RATE   <= mode_ff[1:0];
            HORIZ_FULL   <= fh;
            VERT_FULL    <= fv;
            MODE_ILLEGAL <= (run_ff == ST_RUN) & ~legal;
            PART_LOSS    <= pl;
        end
    end

    // assertions
    onehot_in_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        CLK_EN |=> $onehot(INPUT_EN) && INPUT_EN[$past(INPUT_SEL)])
        else $error("input enable not one-hot of select");
    clamp_close_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        CLK_EN |=> CLAMP_CLOSE == $past(lvl_ff[3]))
        else $error("clamp not following clamp pulse");
    tag_excl_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OVL_OE != TOP_BITS_OE)
        else $error("overlay and converter both drive");
    tag_bits_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OVL_OE |-> PIXEL_OUT[7] == PIXEL_OUT[6])
        else $error("top bits differ under tag");
    shut_end_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        CLK_EN && run_ff == ST_RUN && line_ff != '0
        && line_ff >= LINE_W'(shut_len) |=> !shut_ff)
        else $error("shutter not ended at length");
    line_clr_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        CLK_EN && run_ff == ST_RUN && field_rise |=> line_ff == '0)
        else $error("line count not cleared");
    bypass_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        CLK_EN |=> BYPASS_PIX == $past(PIXEL_IN[7:5]))
        else $error("bypass pixel wrong");
    mode_hold_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        run_ff == ST_RUN && $past(run_ff) == ST_RUN |-> $stable(mode_ff))
        else $error("mode changed while running");
    shut_c: cover property (@(posedge MCLK) disable iff (!RESET_N)
        $rose(SHUTTER));
    tag_c: cover property (@(posedge MCLK) disable iff (!RESET_N)
        $rose(OVL_OE));
    illegal_c: cover property (@(posedge MCLK) disable iff (!RESET_N)
        MODE_ILLEGAL);
endmodule : capture_ctrl

// ==== bench/video_source.sv ====
/*
 * partner model: sync, line, clamp and first-line pins of the capture
 * block, as a camera sync source would present them.
 * assumes one bench process calls its tasks, aligned to mclk edges.
 */
module video_source (
    input  wire logic mclk,        // system clock
    output logic      field_start, // field start strobe
    output logic      line_start,  // line period strobe
    output logic      line_active, // line active level
    output logic      clamp_pulse, // back porch clamp level
    output logic      first_line,  // first digitized line level
    output int        line_no      // line strobes since field start
);
    timeunit 1ns;
    timeprecision 100ps;
    // all pins idle low from time zero
    initial begin
        {field_start, line_start, line_active, clamp_pulse} = 4'h0;
        first_line = 1'b0;
        line_no = 0;
    end
    // pass n edges, then settle just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : step
    // park first-line and clamp pins at fixed levels
    task automatic hold(input logic first, input logic clamp);
        step(1);
        first_line = first;
        clamp_pulse = clamp;
    endtask : hold
    // field strobe, then one strobe per later line; lines long enough
    // that the shutter always settles inside the line that ends it
    task automatic run_field(input int n);
        step(1);
        first_line = 1'b0;
        field_start = 1'b1;
        line_no = 0;
        step(4);
        field_start = 1'b0;
        for (int k = 0; k < n; k++) begin
            if (k > 0) begin
                line_start = 1'b1;
                line_no = line_no + 1;
                step(4);
                line_start = 1'b0;
            end
            clamp_pulse = 1'b1;
            step(4);
            clamp_pulse = 1'b0;
            line_active = 1'b1;
            step(18);
            line_active = 1'b0;
            step(4);
        end
    endtask : run_field
endmodule : video_source

// ==== bench/video_capture_mode_control_bench.sv ====
/*
 * self-checking bench of the capture control block: mode table,
 * pixel path, overlay, clamp, sample tick and shutter length.
 * assumes the sync source model in video_source.sv.
 */
module video_capture_mode_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import capture_pkg::*;
    // legal modes: {six, br[1:0], fr[1:0], h full, v full, loss}
    localparam logic [7:0] MODES [16] = '{8'hFC, 8'hDF, 8'hD4, 8'hB6,
        8'hAC, 8'h8E, 8'h84, 8'h78, 8'h5C, 8'h50, 8'h3F, 8'h34, 8'h28,
        8'h16, 8'h0C, 8'h00};
    localparam logic [7:0] LENS [8] = '{SHUT_LEN_0, SHUT_LEN_1,
        SHUT_LEN_2, SHUT_LEN_3, SHUT_LEN_4, SHUT_LEN_5, SHUT_LEN_6,
        SHUT_LEN_7};
    localparam int LIMIT = 60000; // run needs about 31500 cycles
    logic        mclk, reset_n, clk_en, pix_six, comp_right, overlay_in;
    logic [2:0]  shut_sel, bypass_pix;
    logic [1:0]  input_sel, bit_rate_sel, frame_rate_sel;
    logic [1:0]  bit_rate, frame_rate;
    logic [7:0]  pixel_in, pixel_out;
    logic [3:0]  input_en;
    logic        shutter, clamp_close, sample_tick, top_bits_oe, ovl_oe;
    logic        ovl_out, pix_six_out, compress_on, horiz_full;
    logic        vert_full, mode_illegal, part_loss, prev_sh, armed;
    logic        field_start, line_start, line_active, clamp_pulse;
    logic        first_line;
    logic [28:0] act;            // compared output vector
    logic [28:0] pix_q [$];      // expected vectors, one per cycle
    logic [31:0] shut_q [$];     // expected shutter lengths
    int          fails = 0, total_checks = 0, cycles = 0;
    int          gap = 0, since_rst = 0, exp_tick = 11;
    int          seed = 32'h83de_f477;
    int          line_no;
    assign act = {input_en, pixel_out, bypass_pix, pix_six_out,
        compress_on, bit_rate, frame_rate, horiz_full, vert_full,
        mode_illegal, part_loss, ovl_oe, ovl_out, top_bits_oe,
        clamp_close};
    capture_ctrl #(.LINE_W(9)) u_dut (
        .MCLK(mclk), .RESET_N(reset_n), .CLK_EN(clk_en),
        .SHUT_SEL(shut_sel), .FIELD_START(field_start),
        .LINE_START(line_start), .LINE_ACTIVE(line_active),
        .CLAMP_PULSE(clamp_pulse), .FIRST_LINE(first_line),
        .INPUT_SEL(input_sel), .PIX_SIX(pix_six),
        .BIT_RATE_SEL(bit_rate_sel), .FRAME_RATE_SEL(frame_rate_sel),
        .COMP_RIGHT(comp_right), .OVERLAY_IN(overlay_in),
        .PIXEL_IN(pixel_in), .SHUTTER(shutter), .INPUT_EN(input_en),
        .CLAMP_CLOSE(clamp_close), .SAMPLE_TICK(sample_tick),
        .TOP_BITS_OE(top_bits_oe), .OVL_OE(ovl_oe), .OVL_OUT(ovl_out),
        .PIXEL_OUT(pixel_out), .BYPASS_PIX(bypass_pix),
        .PIX_SIX_OUT(pix_six_out), .COMPRESS_ON(compress_on),
        .BIT_RATE(bit_rate), .FRAME_RATE(frame_rate),
        .HORIZ_FULL(horiz_full), .VERT_FULL(vert_full),
        .MODE_ILLEGAL(mode_illegal), .PART_LOSS(part_loss));
    video_source u_src (
        .mclk(mclk), .field_start(field_start), .line_start(line_start),
        .line_active(line_active), .clamp_pulse(clamp_pulse),
        .first_line(first_line), .line_no(line_no));
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    // compare one value, count it, report a mismatch
    task automatic check(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask : check
    // verdict and end of run
    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // pass n edges, drive just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : step
    // one reset with mode i, a random pixel burst, then one field
    task automatic run_mode(input int i);
        logic [7:0] ent, pix, len;
        logic       first, clamp, ill, ov, comp;
        logic [1:0] sel;
        logic [28:0] exp_v, last_v;
        ent = (i < 16) ? MODES[i] : 8'hF0; // last one is outside table
        ill = (i == 16);
        first = i[0];
        clamp = i[1];
        len = LENS[i % 8];
        comp = 1'($random(seed));
        step(1);
        reset_n = 1'b0;
        {pix_six, bit_rate_sel, frame_rate_sel} = ent[7:3];
        comp_right = comp;
        shut_sel = i[2:0];
        exp_tick = ent[2] ? FULL_DIV : HALF_DIV;
        step(3);
        reset_n = 1'b1;
        step(2);
        // selects moved after the latch must be ignored
        {pix_six, bit_rate_sel, frame_rate_sel, shut_sel, comp_right} =
            9'($random(seed));
        u_src.hold(first, clamp);
        step(8);
        for (int k = 0; k < 12; k++) begin
            sel = 2'($random(seed));
            pix = 8'($random(seed));
            ov = 1'($random(seed));
            input_sel = sel;
            pixel_in = pix;
            overlay_in = ov;
            exp_v = {4'h1 << sel, first ? {ov, ov, pix[5:0]} : pix,
                pix[7:5], ent[7], comp, ent[6:3], ent[2], ent[1], ill,
                ent[0], first, first & ov, ~first, clamp};
            // a frozen edge leaves every output as it was
            clk_en = (k == 0) || (2'($random(seed)) != 2'h0);
            if (clk_en) last_v = exp_v;
            pix_q.push_back(last_v);
            step(1);
        end
        clk_en = 1'b1;
        shut_q.push_back(32'(len));
        u_src.run_field(int'(len) + 2);
    endtask : run_mode
    // main sequence: 20 cycles of reset, then every mode
    initial begin
        mclk = 1'b0;
        {reset_n, clk_en, pix_six, comp_right, overlay_in} = 5'h0A;
        {shut_sel, input_sel, bit_rate_sel, frame_rate_sel} = 9'h000;
        pixel_in = 8'h00;
        prev_sh = 1'b0;
        armed = 1'b0;
        repeat (20) @(posedge mclk);
        for (int i = 0; i < 17; i++) run_mode(i);
        step(4);
        check(32'(shut_q.size()), 32'h0000_0000);
        report_and_stop();
    end
    // watcher: settled outputs against the oldest notes
    always @(posedge mclk) begin
        #1;
        if (pix_q.size() > 0)
            check(32'(act), 32'(pix_q.pop_front()));
        if (reset_n === 1'b1 && prev_sh === 1'b1 && shutter === 1'b0)
            check(32'(line_no), shut_q.size() > 0 ? shut_q.pop_front() : 32'hFFFF_FFFF);
        prev_sh = shutter;
        since_rst = (reset_n === 1'b1) ? since_rst + 1 : 0;
        // tick spacing, judged once the latched mode has settled
        if (since_rst < 30) begin
            gap = 1;
            armed = 1'b0;
        end else if (sample_tick === 1'b1 || gap > 3 * HALF_DIV) begin
            if (armed || gap > 3 * HALF_DIV)
                check(32'(gap), 32'(exp_tick));
            armed = 1'b1;
            gap = 1;
        end else gap++;
    end
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            report_and_stop();
        end
    end
endmodule : video_capture_mode_control_bench
